// ==== logic/bit_sync_pkg.sv ====
/*
 * Constants shared by the bit synchroniser loop: register indices and
 * byte addresses, field positions, reset values and datapath widths.
 * Assumes a 32-bit APB bus with one register per aligned word.
 */
package bit_sync_pkg;

    // ****************************************************************
    // Register map (printed offsets are indices, byte address = 4 * index)
    // ****************************************************************
    localparam logic [7:0] IDX_FOC_CFG = 8'h19;
    localparam logic [7:0] IDX_BS_CFG = 8'h1a;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_FOC_CFG = {2'h0, IDX_FOC_CFG, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_BS_CFG = {2'h0, IDX_BS_CFG, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] FOC_CFG_RESET = 8'h36;
    localparam logic [7:0] BS_CFG_RESET = 8'h6c;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int PRE_KI_LSB = 6;
    localparam int PRE_KP_LSB = 4;
    localparam int POST_KI_BIT = 3;
    localparam int POST_KP_BIT = 2;
    localparam int LIMIT_LSB = 0;
    localparam int GATE_BIT = 5;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_FROZEN_BIT = 1;
    localparam int ST_COMP_BIT = 2;
    localparam int ST_CORR_LSB = 16;

    // ****************************************************************
    // Datapath: correction full scale is 2**RATE_FRAC (100 % data rate)
    // ****************************************************************
    localparam int ERR_W = 8;
    localparam int ACC_W = 14;
    localparam int RATE_FRAC = 12;
    localparam int LIM_SHIFT_BASE = RATE_FRAC - 6;

endpackage

// ==== logic/loop_ctrl_if.sv ====
/*
 * Carrier between the register/control side and the loop filter.
 * Assumes both ends share one clock; no timing of its own.
 */
interface loop_ctrl_if;
    import bit_sync_pkg::*;

    logic [3:0] ki_halves;
    logic [2:0] kp_mult;
    logic [ACC_W-1:0] limit;
    logic comp_en;
    logic freeze;
    logic signed [ACC_W-1:0] rate_corr;
    logic signed [ACC_W:0] phase_adj;

    modport ctrl (output ki_halves, kp_mult, limit, comp_en, freeze,
                  input rate_corr, phase_adj);
    modport filter (input ki_halves, kp_mult, limit, comp_en, freeze,
                    output rate_corr, phase_adj);
endinterface

// ==== logic/clock_recovery_filter.sv ====
/*
 * Proportional-integral loop filter of the symbol clock recovery.
 * Assumes phase_err comes from demodulator logic on the same clock.
 */
module clock_recovery_filter
    import bit_sync_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic signed [ERR_W-1:0] phase_err,
    loop_ctrl_if.filter lp
);

    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W-1:0] acc_d;
    logic signed [ACC_W:0] phase_q;
    logic signed [ACC_W:0] phase_d;
    logic signed [ERR_W+4:0] int_step;
    logic signed [ERR_W+3:0] prop_step;
    logic signed [ACC_W:0] acc_sum;
    logic signed [ACC_W:0] lim_pos;
    logic signed [ACC_W:0] lim_neg;

    // ****************************************************************
    // Integral path: tracks a steady rate offset, in half-Ki units
    // ****************************************************************
    assign int_step = phase_err * $signed({1'b0, lp.ki_halves});
    assign prop_step = phase_err * $signed({1'b0, lp.kp_mult});
    assign acc_sum = {acc_q[ACC_W-1], acc_q} + (ACC_W+1)'(int_step);
    assign lim_pos = $signed({1'b0, lp.limit});
    assign lim_neg = -lim_pos;

    // Clamp, hold while frozen, or clear when compensation is off
    always_comb begin
        acc_d = acc_q;
        phase_d = '0;
        if (!lp.comp_en) begin
            acc_d = '0;
        end else if (!lp.freeze) begin
            if (acc_sum > lim_pos) begin
                acc_d = lp.limit;
            end else if (acc_sum < lim_neg) begin
                acc_d = ACC_W'(lim_neg);
            end else begin
                acc_d = ACC_W'(acc_sum);
            end
        end
        // Whole phase adjustment, integral term included, is zeroed while frozen so the phase stays put
        if (!lp.freeze) begin
            phase_d = (ACC_W+1)'(prop_step) + {acc_d[ACC_W-1], acc_d};
        end
    end

    // Loop state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            phase_q <= '0;
        end else begin
            acc_q <= acc_d;
            phase_q <= phase_d;
        end
    end

    assign lp.rate_corr = acc_q;
    assign lp.phase_adj = phase_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_NO_COMP: assert property (!lp.comp_en |=> acc_q == 0)
        else $error("Rate correction nonzero with compensation off");
    AST_SATURATE: assert property ($signed({1'b0, lp.limit}) >= acc_q
        && acc_q >= -$signed({1'b0, lp.limit}) || $changed(lp.limit))
        else $error("Rate correction beyond limit");
    AST_FREEZE_HOLD: assert property (lp.freeze && lp.comp_en
        |=> $stable(acc_q) && phase_q == 0)
        else $error("Loop moved while frozen");
    AST_INT_TRACK: assert property (lp.comp_en && !lp.freeze && phase_err > 0
        && $stable(lp.limit) && acc_q < $signed({1'b0, lp.limit}) |=> acc_q > $past(acc_q))
        else $error("Integral path did not follow positive error");

endmodule

// ==== logic/bit_sync_loop.sv ====
/*
 * Bit synchroniser loop configuration with APB register access and the
 * gain scheduling around sync word detection.
 * Assumes sync_detected, search_start, carrier_sense and phase_err come
 * from demodulator logic on mclk, so they are not resynchronised.
 */
// Local design decision: the APB interface to the registers.
module bit_sync_loop
    import bit_sync_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [ERR_W-1:0] phase_err,
    input wire logic sync_detected,
    input wire logic search_start,
    input wire logic carrier_sense,
    output logic signed [ACC_W-1:0] rate_correction,
    output logic signed [ACC_W:0] phase_adjust,
    output logic sync_locked
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] bs_cfg_q;
    logic [7:0] foc_cfg_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic sync_found_q;
    logic sync_found_d;
    logic [31:0] status_w;
    logic [31:0] rd_mux;
    logic hit_bs;
    logic hit_foc;
    logic hit_st;
    logic hit_any;
    logic setup_ph;
    logic wr_take;

    // Address decode and phase qualifiers
    assign hit_bs = paddr == ADDR_BS_CFG;
    assign hit_foc = paddr == ADDR_FOC_CFG;
    assign hit_st = paddr == ADDR_STATUS;
    assign hit_any = hit_bs || hit_foc || hit_st;
    assign setup_ph = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite;

    // Zero wait states: answer always comes in the first access cycle
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Read mux; unmapped words read zero and flag an error
    assign rd_mux = hit_bs ? {24'h000000, bs_cfg_q} :
                    hit_foc ? {24'h000000, foc_cfg_q} :
                    hit_st ? status_w : 32'h00000000;

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= !hit_any;
        end
    end

    // Configuration writes land on the access edge only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bs_cfg_q <= BS_CFG_RESET;
            foc_cfg_q <= FOC_CFG_RESET;
        end else if (wr_take) begin
            if (hit_bs) begin
                bs_cfg_q <= pwdata[7:0];
            end
            if (hit_foc) begin
                foc_cfg_q <= pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Sync tracking and gain scheduling
    // ****************************************************************
    logic [1:0] pre_ki;
    logic [1:0] pre_kp;
    logic [1:0] lim_code;
    logic post_ki_sel;
    logic post_kp_sel;
    logic [3:0] ki_pre_halves;
    logic [2:0] kp_pre_mult;
    logic freeze_w;

    assign pre_ki = bs_cfg_q[PRE_KI_LSB +: 2];
    assign pre_kp = bs_cfg_q[PRE_KP_LSB +: 2];
    assign lim_code = bs_cfg_q[LIMIT_LSB +: 2];
    assign post_ki_sel = bs_cfg_q[POST_KI_BIT];
    assign post_kp_sel = bs_cfg_q[POST_KP_BIT];

    // A detection in the same cycle as a restart wins, so no lock is lost
    assign sync_found_d = sync_detected ? 1'b1 :
                          search_start ? 1'b0 : sync_found_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_found_q <= 1'b0;
        end else begin
            sync_found_q <= sync_found_d;
        end
    end

    assign sync_locked = sync_found_q;

    // Integral gain is carried in half-Ki units so Ki/2 stays exact
    assign ki_pre_halves = 4'(({2'h0, pre_ki} + 4'h1) << 1);
    assign kp_pre_mult = {1'b0, pre_kp} + 3'h1;

    loop_ctrl_if lp ();

    assign lp.ki_halves = (sync_found_q && post_ki_sel) ? 4'h1 : ki_pre_halves;
    assign lp.kp_mult = (sync_found_q && post_kp_sel) ? 3'h1 : kp_pre_mult;

    // Limit of 2**(LIM_SHIFT_BASE+code): 3.125, 6.25 or 12.5 % of full scale
    assign lp.comp_en = lim_code != 2'h0;
    assign lp.limit = lp.comp_en ?
        ACC_W'(ACC_W'(1) << (LIM_SHIFT_BASE + int'(lim_code))) : '0;

    // Hold the loop until the channel shows a carrier
    assign freeze_w = foc_cfg_q[GATE_BIT] && !carrier_sense;
    assign lp.freeze = freeze_w;

    clock_recovery_filter u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .phase_err(phase_err),
        .lp(lp.filter)
    );

    assign rate_correction = lp.rate_corr;
    assign phase_adjust = lp.phase_adj;

    // Status word shows the loop's live state
    assign status_w = {{(16 - ACC_W){lp.rate_corr[ACC_W-1]}}, lp.rate_corr,
                       13'h0000, lp.comp_en, freeze_w, sync_found_q};

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Lock takes one cycle to register after the detection pulse
    sequence s_locked;
        sync_detected ##1 sync_found_q;
    endsequence

    AST_PRE_KI: assert property (!sync_found_q
        |-> lp.ki_halves == 4'(2 * (int'(pre_ki) + 1)))
        else $error("Pre-sync integral gain wrong");
    AST_PRE_KP: assert property (!sync_found_q
        |-> lp.kp_mult == 3'(int'(pre_kp) + 1))
        else $error("Pre-sync proportional gain wrong");
    AST_POST_KI: assert property (s_locked |-> lp.ki_halves ==
        (post_ki_sel ? 4'h1 : 4'(2 * (int'(pre_ki) + 1))))
        else $error("Post-sync integral gain wrong");
    AST_POST_KP: assert property (s_locked |-> lp.kp_mult ==
        (post_kp_sel ? 3'h1 : 3'(int'(pre_kp) + 1)))
        else $error("Post-sync proportional gain wrong");
    AST_RESTART: assert property (search_start && !sync_detected
        |=> !sync_found_q && lp.ki_halves == 4'(2 * (int'(pre_ki) + 1))
        && lp.kp_mult == 3'(int'(pre_kp) + 1))
        else $error("Search restart kept post-sync gains");
    AST_LIMIT_SEL: assert property (lim_code == 2'h1
        |-> lp.limit == ACC_W'(128))
        else $error("3.125 percent limit wrong");
    AST_GATE: assert property (foc_cfg_q[GATE_BIT] && !carrier_sense
        |-> lp.freeze ##1 phase_adjust == 0)
        else $error("Loop not frozen without carrier");
    AST_APB_ERR: assert property (setup_ph && !hit_any |=> pslverr && pready)
        else $error("Unmapped access not flagged");
    AST_RD_OK: assert property (setup_ph && hit_any |=> !pslverr && pready)
        else $error("Mapped access flagged as error");

    // Writes land on the access edge, so one transfer updates one register
    AST_WR_BS: assert property (wr_take && hit_bs
        |=> bs_cfg_q == $past(pwdata[7:0]))
        else $error("Bit sync configuration write lost");
    AST_WR_FOC: assert property (wr_take && hit_foc
        |=> foc_cfg_q == $past(pwdata[7:0]))
        else $error("Frequency offset configuration write lost");

    // Every limit code maps to its own clamp; code zero switches rate compensation off
    AST_LIMIT_MID: assert property (lim_code == 2'h2
        |-> lp.limit == ACC_W'(256))
        else $error("6.25 percent limit wrong");
    AST_LIMIT_TOP: assert property (lim_code == 2'h3
        |-> lp.limit == ACC_W'(512))
        else $error("12.5 percent limit wrong");
    AST_COMP_OFF: assert property (lim_code == 2'h0
        |-> !lp.comp_en && lp.limit == 0)
        else $error("Compensation left on with zero limit");

    // Lock follows a detection; the gate must never hold a loop with carrier
    AST_SYNC_SET: assert property (sync_detected |=> sync_found_q)
        else $error("Sync detection not registered");
    AST_CARRIER_RUN: assert property (carrier_sense || !foc_cfg_q[GATE_BIT]
        |-> !lp.freeze)
        else $error("Loop frozen with carrier present");

endmodule

// ==== verification/bit_sync_loop_tb_top.sv ====
/*
 * Self-checking bench for bit_sync_loop: APB register access, gain scheduling,
 * saturation, freeze gating and sync tracking, all checked at the ports.
 * Assumes the bit_sync_pkg constants and a zero-wait APB slave as handed over.
 */
module bit_sync_loop_tb_top
    import bit_sync_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [ERR_W-1:0] phase_err = '0;
    logic sync_detected = 1'b0;
    logic search_start = 1'b0;
    logic carrier_sense = 1'b0;
    logic signed [ACC_W-1:0] rate_correction;
    logic signed [ACC_W:0] phase_adjust;
    logic sync_locked;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;

    bit_sync_loop dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_err(phase_err),
        .sync_detected(sync_detected), .search_start(search_start),
        .carrier_sense(carrier_sense), .rate_correction(rate_correction),
        .phase_adjust(phase_adjust), .sync_locked(sync_locked));

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    always #12.5 mclk = ~mclk;

    // Whole run needs well under a thousand cycles; this leaves ample margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            close_out();
        end
    end

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic close_out();
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [31:0] exp,
                          input logic [APB_AW-1:0] a, input logic exp_err);
        apb(1'b0, a, 8'h0);
        chk(what, exp, rd);
        chk("pslverr", {31'h0, exp_err}, {31'h0, er});
    endtask

    // Limit 00 first so the accumulator starts from zero, then the real value
    task automatic set_cfg(input logic [7:0] v);
        apb(1'b1, ADDR_BS_CFG, {v[7:2], 2'b00});
        repeat (2) @(posedge mclk);
        apb(1'b1, ADDR_BS_CFG, v);
        repeat (2) @(posedge mclk);
    endtask

    // Holds an error for n sampled edges, then waits 1 ns for the result to settle
    task automatic err_for(input logic signed [ERR_W-1:0] e, input int n);
        @(posedge mclk);
        phase_err <= e;
        repeat (n - 1) @(posedge mclk);
        @(posedge mclk);
        phase_err <= '0;
        #1;
    endtask

    task automatic loop_chk(input int rc, input int pa);
        chk("rate_correction", rc, rate_correction);
        chk("phase_adjust", pa, phase_adjust);
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk("bs_cfg reset", {24'h0, 8'h6c}, ADDR_BS_CFG, 1'b0);
        rd_chk("foc_cfg reset", {24'h0, 8'h36}, ADDR_FOC_CFG, 1'b0);
        rd_chk("unmapped read", 32'h0, 12'h004, 1'b1);
        // A stray write must be flagged and must not land anywhere
        apb(1'b1, 12'h004, 8'h55);
        chk("pslverr write", 32'h1, {31'h0, er});
        rd_chk("bs_cfg after stray", {24'h0, 8'h6c}, ADDR_BS_CFG, 1'b0);
        // Gate set and no carrier: loop stays frozen
        set_cfg(8'hc3);
        err_for(8'sd5, 2);
        loop_chk(0, 0);
        rd_chk("status frozen", 32'h0000_0006, ADDR_STATUS, 1'b0);
        carrier_sense <= 1'b1;
        err_for(8'sd5, 2);
        loop_chk(80, 85);
        apb(1'b1, ADDR_FOC_CFG, 8'h16);
        rd_chk("foc_cfg write", {24'h0, 8'h16}, ADDR_FOC_CFG, 1'b0);
        // Every pre-sync gain code; two cycles of steady error accumulate
        for (int i = 0; i < 4; i++) begin
            set_cfg({i[1:0], 2'(3 - i), 4'b0011});
            err_for(8'sd3, 2);
            loop_chk(12 * (i + 1), 3 * (4 - i) + 12 * (i + 1));
        end
        // Saturation at every nonzero limit code, both signs
        for (int c = 1; c < 4; c++) begin
            set_cfg({6'b110000, 2'(c)});
            err_for(8'sd127, 2);
            chk("rate_correction pos", 64 << c, rate_correction);
            err_for(-8'sd127, 2);
            chk("rate_correction neg", -(64 << c), rate_correction);
        end
        rd_chk("status sat", 32'hfe00_0004, ADDR_STATUS, 1'b0);
        apb(1'b1, ADDR_BS_CFG, 8'hc0);
        err_for(8'sd5, 2);
        chk("rate_correction off", 0, rate_correction);
        rd_chk("status off", 32'h0, ADDR_STATUS, 1'b0);
        // Post-sync gains, then a new search restores the pre-sync ones
        @(posedge mclk);
        sync_detected <= 1'b1;
        @(posedge mclk);
        sync_detected <= 1'b0;
        set_cfg(8'hff);
        chk("sync_locked", 1, sync_locked);
        err_for(8'sd3, 1);
        loop_chk(3, 6);
        set_cfg(8'hf3);
        err_for(8'sd3, 1);
        loop_chk(24, 36);
        set_cfg(8'hff);
        @(posedge mclk);
        search_start <= 1'b1;
        @(posedge mclk);
        search_start <= 1'b0;
        set_cfg(8'hff);
        chk("sync_locked", 0, sync_locked);
        err_for(8'sd3, 1);
        loop_chk(24, 36);
        // Detection and new search together: detection wins
        @(posedge mclk);
        sync_detected <= 1'b1;
        search_start <= 1'b1;
        @(posedge mclk);
        sync_detected <= 1'b0;
        search_start <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("sync_locked both", 1, sync_locked);
        close_out();
    end
endmodule
